// >>> hdl/spm_top.sv
/*
 * Power-mode controller with energy detect, soft power-down, per-port
 * power-down and low-power-idle assert/detect on one MII.
 * Assumes a 50 MHz clock, inputs synchronous to it, and a classic
 * Wishbone master with 32-bit data and byte addresses.
 */
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_top #(
   parameter int unsigned PORTS    = 3,
   parameter int unsigned TICK_CYC = `SPM_TICK_CYC,
   parameter int unsigned SEC_CYC  = `SPM_SEC_CYC,
   parameter int unsigned WAKE_CYC = `SPM_WAKE_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              resetn_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              energy_i,
   input  wire logic [PORTS-1:0]  phy_ctl_pd_i,
   input  wire logic              partner_eee_cap_i,
   input  wire spm_pkg::spm_mii_t mac_tx_i,
   output spm_pkg::spm_mii_t      mii_tx_o,
   input  wire spm_pkg::spm_mii_t mii_rx_i,
   output spm_pkg::spm_mii_t      mac_rx_o,
   output logic                   partner_low_power_flag_o,
   output logic                   mac_tx_allow_o,
   output logic                   mac_crs_o,
   output logic                   mac_tx_clk_en_o,
   output logic                   mac_rx_clk_en_o,
   output logic                   pll_en_o,
   output logic                   mac_en_o,
   output logic                   host_if_en_o,
   output logic                   energy_det_en_o,
   output logic [PORTS-1:0]       phy_en_o,
   output logic                   link_pulse_o
);

   // ===================================================================
   // Registers and state
   // ===================================================================
   spm_pkg::spm_mode_t mode_r;
   logic [7:0]         sleep_r;
   logic [7:0]         pctl_r [PORTS];
   logic [7:0]         eee_r;
   logic               low_r;
   logic [7:0]         idle_ticks_r;
   logic [31:0]        tick_cnt_r;
   logic [31:0]        sec_cnt_r;
   logic               tx_lpi_r;
   logic [15:0]        wake_cnt_r;

   // ===================================================================
   // Bus decode
   // ===================================================================
   // A request is taken once, in the cycle before the acknowledge.
   wire       wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [5:0] idx        = wb_adr_i[7:2];
   wire       in_spd     = (mode_r == spm_pkg::SPM_SOFT_PD);
   wire       wake_spd   = wb_req & in_spd;
   // Writes land only while the host interface is powered.
   wire       wr_ok      = wb_req & wb_we_i & wb_sel_i[0] & ~in_spd & ~low_r;
   wire [1:0] wr_mode    = wb_dat_i[`SPM_MODE_MSB:`SPM_MODE_LSB];
   wire       wr_pmode   = wr_ok & (idx == `SPM_IDX_PMODE);
   wire       wr_sleep   = wr_ok & (idx == `SPM_IDX_SLEEP);
   wire       wr_eee     = wr_ok & (idx == `SPM_IDX_EEE_CTL);
   wire       mode_rsvd  = (wr_mode == 2'(spm_pkg::SPM_RESERVED));

   // Port control register selects.
   logic [PORTS-1:0] wr_pctl;
   logic [7:0]       pctl_rd;
   always_comb begin
      pctl_rd = 8'h00;
      for (int p = 0; p < PORTS; p++) begin
         wr_pctl[p] = wr_ok & (idx == 6'(p + 1) * 6'h10 + 6'h0D);
         if (idx == 6'(p + 1) * 6'h10 + 6'h0D) begin
            pctl_rd = pctl_r[p];
         end
      end
   end

   // ===================================================================
   // Power-mode state
   // ===================================================================
   wire tick      = (tick_cnt_r == TICK_CYC - 1);
   wire ed_mode   = (mode_r == spm_pkg::SPM_ENERGY_DET);
   wire go_sleep  = ed_mode & tick & ~energy_i & (idle_ticks_r > sleep_r);

   // Read data mux; unmapped indices read as zero.
   wire [7:0] status = {3'h0, tx_lpi_r, partner_low_power_flag_o,
                        low_r, mode_r};
   wire [7:0] rd_byte =
      (idx == `SPM_IDX_PMODE)   ? {3'h0, mode_r, 3'h0} :
      (idx == `SPM_IDX_SLEEP)   ? sleep_r :
      (idx == `SPM_IDX_EEE_CTL) ? eee_r :
      (idx == `SPM_IDX_STATUS)  ? status : pctl_rd;

   // Bus acknowledge and read data; each access acks one cycle later.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= {24'h00_0000, (in_spd ? 8'h00 : rd_byte)};
      end
   end

   // Software registers; a soft power-down access restores defaults.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_r  <= spm_pkg::SPM_NORMAL;
         sleep_r <= `SPM_SLEEP_RST;
         eee_r   <= `SPM_EEE_RST;
         for (int p = 0; p < PORTS; p++) pctl_r[p] <= `SPM_PCTL_RST;
      end else if (wake_spd) begin
         mode_r  <= spm_pkg::SPM_NORMAL;
         sleep_r <= `SPM_SLEEP_RST;
         eee_r   <= `SPM_EEE_RST;
         for (int p = 0; p < PORTS; p++) pctl_r[p] <= `SPM_PCTL_RST;
      end else begin
         if (wr_pmode && !mode_rsvd) begin
            mode_r <= spm_pkg::spm_mode_t'(wr_mode);
         end
         if (wr_sleep) sleep_r <= wb_dat_i[7:0];
         if (wr_eee) eee_r <= wb_dat_i[7:0];
         for (int p = 0; p < PORTS; p++) begin
            if (wr_pctl[p]) pctl_r[p] <= wb_dat_i[7:0];
         end
      end
   end

   // Energy-detect sleep timing in go-sleep ticks.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_r   <= 32'h0000_0000;
         idle_ticks_r <= 8'h00;
         low_r        <= 1'b0;
      end else begin
         tick_cnt_r <= (tick || !ed_mode) ? 32'h0000_0000 : tick_cnt_r + 1;
         if (!ed_mode || energy_i) begin
            idle_ticks_r <= 8'h00;
            low_r        <= 1'b0;
         end else begin
            if (tick && idle_ticks_r != 8'hFF) begin
               idle_ticks_r <= idle_ticks_r + 8'h01;
            end
            if (go_sleep) low_r <= 1'b1;
         end
      end
   end

   // Once-per-second link pulse while asleep without a cable.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sec_cnt_r    <= 32'h0000_0000;
         link_pulse_o <= 1'b0;
      end else begin
         sec_cnt_r <= (!low_r || sec_cnt_r == SEC_CYC - 1) ? 32'h0000_0000
                                                           : sec_cnt_r + 1;
         link_pulse_o <= low_r && (sec_cnt_r < `SPM_PULSE_CYC);
      end
   end

   // Block enables per mode: clocks, MAC, host, PHYs, energy detector.
   wire run = (mode_r == spm_pkg::SPM_NORMAL) | (ed_mode & ~low_r);
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pll_en_o        <= 1'b1;
         mac_en_o        <= 1'b1;
         host_if_en_o    <= 1'b1;
         energy_det_en_o <= 1'b0;
         phy_en_o        <= '1;
      end else begin
         pll_en_o        <= run;
         mac_en_o        <= run;
         host_if_en_o    <= run;
         energy_det_en_o <= ed_mode;
         for (int p = 0; p < PORTS; p++) begin
            phy_en_o[p] <= run & ~pctl_r[p][`SPM_PCTL_PD_BIT]
                           & ~phy_ctl_pd_i[p];
         end
      end
   end

   // ===================================================================
   // Low-power idle, transmit direction
   // ===================================================================
   wire eee_ok  = eee_r[`SPM_EEE_ADV_BIT] & partner_eee_cap_i;
   wire lpi_req = eee_r[`SPM_EEE_REQ_BIT] & eee_ok
                  & (mode_r == spm_pkg::SPM_NORMAL);
   wire waking  = (wake_cnt_r != 16'h0000);
   localparam spm_pkg::spm_mii_t LPI_TX = '{d: `SPM_LPI_TXD, en: 1'b0,
                                            er: 1'b1};

   // Assert LPI while requested, then hold the MAC for the wake delay.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_lpi_r        <= 1'b0;
         wake_cnt_r      <= 16'h0000;
         mii_tx_o        <= '0;
         mac_tx_allow_o  <= 1'b1;
         mac_crs_o       <= 1'b0;
         mac_tx_clk_en_o <= 1'b1;
      end else begin
         tx_lpi_r <= lpi_req;
         if (lpi_req) begin
            wake_cnt_r <= 16'(WAKE_CYC);
         end else if (waking) begin
            wake_cnt_r <= wake_cnt_r - 16'h0001;
         end
         mii_tx_o        <= lpi_req ? LPI_TX
                            : (waking ? '0 : mac_tx_i);
         mac_tx_allow_o  <= ~lpi_req & ~waking;
         mac_crs_o       <= lpi_req | waking;
         mac_tx_clk_en_o <= ~lpi_req;
      end
   end

   // ===================================================================
   // Low-power idle, receive direction (independent of transmit)
   // ===================================================================
   wire rx_lpi = ~mii_rx_i.en & mii_rx_i.er & (mii_rx_i.d == `SPM_LPI_RXD);

   // Show idle and raise the partner flag while Assert LPI is received.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mac_rx_o                 <= '0;
         partner_low_power_flag_o <= 1'b0;
         mac_rx_clk_en_o          <= 1'b1;
      end else begin
         mac_rx_o                 <= rx_lpi ? '0 : mii_rx_i;
         partner_low_power_flag_o <= rx_lpi;
         mac_rx_clk_en_o          <= ~rx_lpi;
      end
   end

   // ===================================================================
   // Assertions
   // ===================================================================
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_spd_access;
      in_spd && wb_req;
   endsequence
   sequence s_back_normal;
      ##1 (mode_r == spm_pkg::SPM_NORMAL) && (eee_r == `SPM_EEE_RST)
      ##1 pll_en_o;
   endsequence
   // Sleep entry: the state first, then the clocks stop.
   sequence s_asleep;
      low_r ##1 !pll_en_o && energy_det_en_o;
   endsequence

   a_rsvd_mode_kept: assert property (wr_pmode && mode_rsvd |=>
      mode_r == $past(mode_r)) else $error("reserved mode changed mode");
   a_spd_wake_reset: assert property (s_spd_access |-> s_back_normal)
      else $error("soft power-down access did not wake and reset");
   a_spd_all_off: assert property (in_spd |=>
      !pll_en_o && !mac_en_o && (phy_en_o == '0))
      else $error("blocks running in soft power-down");
   a_low_energy_off: assert property (low_r |=>
      !pll_en_o && !host_if_en_o && energy_det_en_o)
      else $error("circuits running in low-power state");
   a_energy_wakes: assert property (low_r && energy_i |=> !low_r ##1 pll_en_o)
      else $error("energy did not wake device");
   a_pulse_width: assert property ($rose(link_pulse_o) |->
      link_pulse_o [*6] ##1 !link_pulse_o)
      else $error("link pulse width wrong");
   a_lpi_tx_enc: assert property (lpi_req |=>
      mii_tx_o == LPI_TX && !mac_tx_allow_o && mac_crs_o)
      else $error("LPI request not encoded on transmit");
   a_wake_hold: assert property ($fell(lpi_req) |=>
      !mii_tx_o.er && !mac_tx_allow_o ##1 !mac_tx_allow_o [*2])
      else $error("MAC released before wake delay");
   a_no_cap_no_lpi: assert property (!partner_eee_cap_i && !waking
      |=> mac_tx_allow_o && mii_tx_o == $past(mac_tx_i))
      else $error("LPI without shared capability");
   a_rx_lpi_flag: assert property (rx_lpi |=>
      partner_low_power_flag_o && !mac_rx_o.en && !mac_rx_o.er)
      else $error("receive LPI not shown as idle with flag");
   a_rx_pass: assert property (!rx_lpi |=>
      !partner_low_power_flag_o && mac_rx_o == $past(mii_rx_i))
      else $error("receive signals not passed through");
   a_port_pd: assert property (pctl_r[0][`SPM_PCTL_PD_BIT] ||
      phy_ctl_pd_i[0] |=> !phy_en_o[0]) else $error("port not powered down");

   // Sleep entry timing, clock gating, defer and bus pulse checks.
   a_sleep_entry: assert property (go_sleep |=> s_asleep)
      else $error("go-sleep time elapsed without sleeping");
   a_no_early_sleep: assert property (ed_mode && !low_r &&
      (idle_ticks_r <= sleep_r) |=> !low_r)
      else $error("low-power state entered too early");
   a_flag_drops: assert property ($fell(rx_lpi) |=>
      !partner_low_power_flag_o && mac_rx_clk_en_o)
      else $error("partner flag held after Assert LPI ended");
   a_crs_defer: assert property (!mac_tx_allow_o |-> mac_crs_o)
      else $error("MAC blocked without carrier sense");
   a_tx_clk_gate: assert property (lpi_req |=> !mac_tx_clk_en_o)
      else $error("transmit clock running during LPI");
   a_lpi_normal_only: assert property (!waking &&
      (mode_r != spm_pkg::SPM_NORMAL) |=> mac_tx_allow_o)
      else $error("LPI requested outside normal mode");
   a_normal_runs: assert property (mode_r == spm_pkg::SPM_NORMAL
      |=> pll_en_o && mac_en_o && host_if_en_o)
      else $error("blocks stopped in normal mode");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge longer than one cycle");

endmodule // spm_top

// >>> common/spm_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * switch power-mode and low-power-idle controller.
 * Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
 */
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// ======================================================================
// Register indices (byte address is four times the index)
// ======================================================================
`define SPM_IDX_PMODE     6'h0E
`define SPM_IDX_SLEEP     6'h0F
`define SPM_IDX_PCTL1     6'h1D
`define SPM_IDX_PCTL2     6'h2D
`define SPM_IDX_PCTL3     6'h3D
`define SPM_IDX_EEE_CTL   6'h10
`define SPM_IDX_STATUS    6'h11

// ======================================================================
// Field positions
// ======================================================================
`define SPM_MODE_LSB      3
`define SPM_MODE_MSB      4
`define SPM_PCTL_PD_BIT   3
`define SPM_EEE_REQ_BIT   0
`define SPM_EEE_ADV_BIT   1

// ======================================================================
// Reset values
// ======================================================================
`define SPM_PMODE_RST     8'h00
`define SPM_SLEEP_RST     8'h50
`define SPM_PCTL_RST      8'h00
`define SPM_EEE_RST       8'h00

// ======================================================================
// Timing
// ======================================================================
`define SPM_CLK_PERIOD_NS 20
`define SPM_PULSE_NS      120
`define SPM_PULSE_CYC \
   ((`SPM_PULSE_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS)
`define SPM_SEC_CYC       50000000
`define SPM_TICK_CYC      50000
`define SPM_WAKE_CYC      16

// ======================================================================
// MII encodings
// ======================================================================
`define SPM_LPI_TXD       4'h1
`define SPM_LPI_RXD       4'h1

`endif

// >>> common/spm_pkg.sv
/*
 * Types of the switch power-mode and low-power-idle controller.
 * Assumes the constants of spm_cfg.svh for field widths.
 */
package spm_pkg;

   // ===================================================================
   // Power modes as held in the mode field
   // ===================================================================
   typedef enum logic [1:0] {
      SPM_NORMAL,
      SPM_ENERGY_DET,
      SPM_SOFT_PD,
      SPM_RESERVED
   } spm_mode_t;

   // ===================================================================
   // One direction of a nibble-wide MII
   // ===================================================================
   typedef struct packed {
      logic [3:0] d;
      logic       en;
      logic       er;
   } spm_mii_t;

endpackage

// >>> verif/spm_phy_model.sv
/*
 * PHY-side partner of the power-mode block: sends receive nibbles or the
 * Assert LPI encoding on command, and flags Assert LPI from the switch.
 * Assumes its controls change just after the rising clock edge.
 */
`timescale 1ns/1ps
`include "spm_cfg.svh"

module spm_phy_model (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              lpi_i,
   input  wire logic [3:0]        nib_i,
   input  wire logic              dv_i,
   input  wire spm_pkg::spm_mii_t tx_i,
   output spm_pkg::spm_mii_t      rx_o,
   output logic                   tx_lpi_o
);
   // ===================================================================
   // Receive side
   // ===================================================================
   // The line is driven every cycle, as a real PHY does, so no stale
   // value can masquerade as an idle.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_o <= '0;
      end else if (lpi_i) begin
         rx_o <= '{d: `SPM_LPI_RXD, en: 1'b0, er: 1'b1};
      end else begin
         rx_o <= '{d: nib_i, en: dv_i, er: 1'b0};
      end
   end

   // Transmit side: high while the switch sends Assert LPI.
   assign tx_lpi_o = (tx_i.d == `SPM_LPI_TXD) && !tx_i.en && tx_i.er;
endmodule // spm_phy_model

// >>> verif/tb.sv
/*
 * Self-checking bench of the power-mode block with short tick counts.
 * Assumes a classic Wishbone slave that answers within a few cycles.
 */
`timescale 1ns/1ps
`include "spm_cfg.svh"

module tb;
   localparam int TICK = 4;
   localparam int SEC  = 20;
   localparam int WAKE = 3;
   logic              ref_clk_i = 1'b0, resetn_i = 1'b0;
   logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0]        adr = 8'h00, q;
   logic [3:0]        sel = 4'h0, nib = 4'h0;
   logic [31:0]       dat_w = 32'h0, dat_r, seed = 32'h21C1, rv;
   logic              energy = 1'b0, cap = 1'b0, lpi_cmd = 1'b0, dv = 1'b0;
   logic [2:0]        phy_pd = 3'h0, phy_en;
   spm_pkg::spm_mii_t mac_tx = '0, mii_tx, mii_rx, mac_rx, rx_s, tx_s;
   logic              flag, allow, crs, txce, rxce, pll, mac, host, edet;
   logic              pulse, tx_lpi;
   int                fail_count = 0, n_compared = 0, cycles = 0, n, s;

   // ===================================================================
   // Clock, stimulus source and hang guard
   // ===================================================================
   always #10 ref_clk_i = ~ref_clk_i;

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Random MAC transmit nibbles and PHY receive data every cycle; a
   // transmit error comes only inside a frame, never as Assert LPI.
   always @(posedge ref_clk_i) begin
      rv = xs();
      mac_tx <= '{d: rv[5:2], en: rv[1], er: rv[1] & rv[0]};
      nib <= rv[9:6];
      dv <= rv[10];
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         complete_run();
      end
   end

   spm_top #(.TICK_CYC(TICK), .SEC_CYC(SEC), .WAKE_CYC(WAKE)) DUT (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .energy_i(energy), .phy_ctl_pd_i(phy_pd), .partner_eee_cap_i(cap),
      .mac_tx_i(mac_tx), .mii_tx_o(mii_tx), .mii_rx_i(mii_rx),
      .mac_rx_o(mac_rx), .partner_low_power_flag_o(flag),
      .mac_tx_allow_o(allow), .mac_crs_o(crs), .mac_tx_clk_en_o(txce),
      .mac_rx_clk_en_o(rxce), .pll_en_o(pll), .mac_en_o(mac),
      .host_if_en_o(host), .energy_det_en_o(edet), .phy_en_o(phy_en),
      .link_pulse_o(pulse));

   spm_phy_model phy (.clk_i(ref_clk_i), .resetn_i(resetn_i),
      .lpi_i(lpi_cmd), .nib_i(nib), .dv_i(dv), .tx_i(mii_tx),
      .rx_o(mii_rx), .tx_lpi_o(tx_lpi));

   // ===================================================================
   // Shared tasks
   // ===================================================================
   // Comparison and verdict.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task complete_run();
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One classic Wishbone cycle; held until ack is sampled high.
   task bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
      @(posedge ref_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hF;
      dat_w <= {24'h0, d};
      do begin
         @(posedge ref_clk_i);
      end while (ack !== 1'b1);
      q = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // Level of a watched output: 0 flag, 1 tx LPI, 2 PLL enable, 3 pulse.
   function logic pick(input logic [1:0] w);
      return (w == 2'h0) ? flag : (w == 2'h1) ? tx_lpi
           : (w == 2'h2) ? pll : pulse;
   endfunction

   // Counts falling edges until a watched output reaches a level; a
   // limit that runs out counts as a mismatch.
   task await(input logic [1:0] w, input logic v, input int lim);
      n = 0;
      while (pick(w) !== v && n < lim) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (pick(w) !== v) fail_count++;
   endtask

   // Checks one-cycle pass-through of receive and/or transmit nibbles.
   task pass(input int cnt, input logic do_rx, input logic do_tx);
      repeat (cnt) begin
         @(posedge ref_clk_i);
         rx_s = mii_rx;
         tx_s = mac_tx;
         @(negedge ref_clk_i);
         if (do_rx) chk(mac_rx, rx_s);
         if (do_tx) chk(mii_tx, tx_s);
      end
   endtask

   // ===================================================================
   // Scenarios
   // ===================================================================
   initial begin
      repeat (4) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      // Reset values, an unmapped word and the normal-mode enables.
      bus(0, `SPM_IDX_PMODE, 0); chk(q, 8'h00);
      bus(0, `SPM_IDX_SLEEP, 0); chk(q, 8'h50);
      bus(0, `SPM_IDX_PCTL1, 0); chk(q, 8'h00);
      bus(0, 6'h3F, 0); chk(q, 8'h00);
      @(negedge ref_clk_i); chk({pll, mac, host, edet}, 4'hE);
      // Port power-down from the register and from the PHY bit.
      bus(1, `SPM_IDX_PCTL1, 8'h08);
      phy_pd <= 3'b100;
      repeat (3) @(negedge ref_clk_i); chk(phy_en, 3'b010);
      // Receive low-power idle detection around pass-through.
      pass(16, 1, 1);
      lpi_cmd <= 1'b1;
      await(2'h0, 1'b1, 8); chk(flag, 1'b1);
      pass(8, 0, 1);
      chk({mac_rx, rxce}, 7'h00);
      lpi_cmd <= 1'b0;
      await(2'h0, 1'b0, 8); chk(n <= 3, 1'b1);
      pass(8, 1, 1);
      // Transmit low-power idle: refused without partner capability.
      bus(1, `SPM_IDX_EEE_CTL, 8'h03);
      repeat (4) @(negedge ref_clk_i);
      chk({tx_lpi, allow}, 2'b01);
      cap <= 1'b1;
      await(2'h1, 1'b1, 8); chk(tx_lpi, 1'b1);
      chk({allow, crs, txce}, 3'b010);
      pass(8, 1, 0);
      bus(1, `SPM_IDX_EEE_CTL, 8'h02);
      await(2'h1, 1'b0, 8);
      s = 0;
      while (allow !== 1'b1 && s < 40) begin
         chk({mii_tx, crs}, 7'h01);
         s++;
         @(negedge ref_clk_i);
      end
      chk(s, WAKE);
      pass(8, 1, 1);
      // Reserved mode code keeps normal operation.
      bus(1, `SPM_IDX_PMODE, 8'h18);
      bus(0, `SPM_IDX_STATUS, 0); chk({q[1:0], pll}, 3'b001);
      // Energy detect with a random go-sleep time.
      s = 1 + (xs() % 4);
      bus(1, `SPM_IDX_SLEEP, s[7:0]);
      bus(1, `SPM_IDX_PMODE, 8'h08);
      await(2'h2, 1'b0, 200);
      chk(n >= s * TICK && n <= (s + 3) * TICK, 1'b1);
      chk({pll, mac, host, edet}, 4'h1);
      await(2'h3, 1'b1, SEC + 8);
      await(2'h3, 1'b0, 20); chk(n, `SPM_PULSE_CYC);
      await(2'h3, 1'b1, 40); chk(n + `SPM_PULSE_CYC, SEC);
      await(2'h3, 1'b0, 20);
      energy <= 1'b1;
      await(2'h2, 1'b1, 8); chk(n <= 3, 1'b1);
      // Soft power-down, then a host access restores the defaults.
      phy_pd <= 3'b000;
      bus(1, `SPM_IDX_PMODE, 8'h10);
      repeat (3) @(negedge ref_clk_i);
      chk({pll, mac, phy_en}, 5'h00);
      bus(0, `SPM_IDX_STATUS, 0); chk(q, 8'h00);
      bus(0, `SPM_IDX_PMODE, 0); chk(q, 8'h00);
      bus(0, `SPM_IDX_SLEEP, 0); chk(q, 8'h50);
      bus(0, `SPM_IDX_PCTL1, 0); chk(q, 8'h00);
      bus(0, `SPM_IDX_EEE_CTL, 0); chk(q, 8'h00);
      @(negedge ref_clk_i); chk({pll, phy_en}, 4'hF);
      complete_run();
   end
endmodule // tb
